// ==== inc/clock_mode_pkg.sv ====
package clock_mode_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] RESET_FLAGS_OFFSET = 8'h03;
  localparam logic [7:0] VCO_TARGET_OFFSET = 8'h04;
  localparam logic [7:0] REF_DIV_OFFSET = 8'h05;
  localparam logic [7:0] POST_DIV_OFFSET = 8'h06;
  localparam logic [7:0] STATUS_OFFSET = 8'h07;
  localparam logic [7:0] CLOCK_SELECT_OFFSET = 8'h09;
  localparam logic [7:0] WATCHDOG_CTRL_OFFSET = 8'h0C;
  localparam logic [7:0] OSC_CTRL_OFFSET = 8'h10;

  // reset values
  localparam logic [7:0] VCO_TARGET_RESET = 8'h32; // 50 MHz
  localparam logic [3:0] REF_DIV_RESET = 4'h0;
  localparam logic [4:0] POST_DIV_RESET = 5'h03; // vco divided by 4
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80; // bus clock on pll
  localparam logic [7:0] WATCHDOG_CTRL_RESET = 8'h00;

  // field positions outside the structs
  localparam int STATUS_LOCK_BIT = 3;
  localparam int STATUS_OSC_UP_BIT = 0;
  localparam int OSC_CTRL_ENABLE_BIT = 7;

  // timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int SWITCH_GAP_NS = 10;
  localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_PULSE_NS = 640;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PIN_MASK_NS = 20;
  localparam int PIN_MASK_CYCLES = (PIN_MASK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_FULL_STOP = 2'b01,
    MODE_PSEUDO_STOP = 2'b10
  } stop_mode_e;

  typedef enum logic [1:0] {
    SRC_IRC = 2'b00,
    SRC_OSC = 2'b01,
    SRC_ACLK = 2'b10
  } timer_src_e;

  typedef struct packed {
    logic bus_clock_from_pll_select;
    logic pseudo_stop_select;
    logic cop_stop_aclk_disable;
    logic watchdog_clk_aclk_select;
    logic periodic_timer_pseudo_stop_enable;
    logic watchdog_pseudo_stop_enable;
    logic periodic_timer_clk_select;
    logic watchdog_clk_osc_select;
  } clock_select_s;

  typedef struct packed {
    logic window_enable;
    logic freeze_hold_timers;
    logic [2:0] spare;
    logic [2:0] watchdog_rate;
  } watchdog_ctrl_s;

  typedef struct packed {
    logic power_on;
    logic low_voltage;
    logic watchdog_timeout;
    logic osc_clock_loss;
    logic pll_clock_loss;
  } reset_sources_s;

  typedef struct packed {
    logic count_enable;
    timer_src_e source;
  } timer_clock_s;

endpackage

// ==== design/clock_mode_stop_control.sv ====
`timescale 1ns/100ps
// Summary of operation
// - after any reset the bus clock runs from the pll, internal reference mode
// - pll reset setup targets 50 MHz vco, post divider 0x03 gives divide by 4
// - in internal reference mode the pll reference is the 1 MHz internal clock
// - in bypass mode bus clock is osc clock, pll keeps running to qualify it
// - wait mode behaves exactly like run mode
// - stop instruction enters stop; pll, internal ref and core clocks off, bus clock gates ignore the mode
// - in stop low voltage interrupt and reset are off, power-on detect stays
// - full stop disables oscillator unless pseudo select and osc enable both set
// - full stop without aclk select halts watchdog and periodic timer
// - wake from full stop sets pll select, clears both osc timer selects
// - aclk select clocks watchdog from aclk; stop halts it only if disable set
// - full stop with aclk select halts periodic timer; watchdog stays on aclk
// - pseudo stop without aclk: each timer runs from osc if its enable set
// - pseudo stop with aclk: periodic timer runs from osc if its enable set
// - pseudo stop entry or exit leaves the three clock select bits alone
// - debug active with freeze bit set freezes both timers in run mode while both hold
// - during debug the watchdog can be forced to its longest time-out
// - reset pin is active low, async input, open-drain output on internal reset
// - system reset from power-on, low voltage, watchdog, osc loss, pll loss, pin
module clock_mode_stop_control #(
  parameter int RESET_PULSE = clock_mode_pkg::RESET_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [clock_mode_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [clock_mode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [clock_mode_pkg::DATA_W-1:0] reg_rdata,
  input wire logic stop_request,
  input wire logic wake_event,
  input wire logic background_debug_active,
  input wire logic osc_up_raw,
  input wire logic pll_lock_raw,
  input wire clock_mode_pkg::reset_sources_s reset_sources,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic system_reset,
  output clock_mode_pkg::stop_mode_e stop_mode,
  output logic bus_clock_pll_gate,
  output logic bus_clock_osc_gate,
  output logic core_clock_enable,
  output logic pll_enable,
  output logic internal_ref_enable,
  output logic pll_ref_from_osc,
  output logic osc_run,
  output logic low_voltage_monitor_enable,
  output logic autonomous_periodic_enable,
  output logic [7:0] vco_target_mhz,
  output logic [3:0] ref_divider,
  output logic [4:0] post_divider,
  output clock_mode_pkg::timer_clock_s watchdog_clock,
  output clock_mode_pkg::timer_clock_s periodic_timer_clock,
  output logic watchdog_force_max
);

  clock_mode_pkg::clock_select_s clks_reg;
  clock_mode_pkg::watchdog_ctrl_s wdog_ctrl_reg;
  clock_mode_pkg::stop_mode_e mode_reg;
  clock_mode_pkg::stop_mode_e mode_next;
  clock_mode_pkg::timer_clock_s wdog_next;
  clock_mode_pkg::timer_clock_s rti_next;
  logic osc_enable_reg;
  logic [4:0] reset_flags_reg;
  logic [7:0] vco_reg;
  logic [3:0] ref_div_reg;
  logic [4:0] post_div_reg;
  logic [7:0] rdata_reg;
  logic [2:0] async_in;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;
  logic osc_up_flag;
  logic pll_lock_flag;
  logic pin_low;
  logic pll_gate_reg;
  logic osc_gate_reg;
  logic [1:0] gap_reg;
  logic [7:0] pulse_reg;
  logic [2:0] pin_mask_reg;
  logic reset_trigger;
  logic wr_clks;
  logic [7:0] rd_mux;

  // external levels: three flops, a change counts once stages two and three agree
  assign async_in = {reset_pin_in, pll_lock_raw, osc_up_raw};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          sync1_reg[gi] <= (gi == 2);
          sync2_reg[gi] <= (gi == 2);
          sync3_reg[gi] <= (gi == 2);
          filt_reg[gi] <= (gi == 2);
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate
  assign osc_up_flag = filt_reg[0] & osc_enable_reg;
  assign pll_lock_flag = filt_reg[1];
  assign pin_low = ~filt_reg[2];

  // stop mode sequencer; wait mode is never seen here, it is plain run
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      clock_mode_pkg::MODE_RUN: begin
        if (stop_request) begin
          if (clks_reg.pseudo_stop_select && osc_enable_reg) begin
            mode_next = clock_mode_pkg::MODE_PSEUDO_STOP;
          end else begin
            mode_next = clock_mode_pkg::MODE_FULL_STOP;
          end
        end
      end
      clock_mode_pkg::MODE_FULL_STOP, clock_mode_pkg::MODE_PSEUDO_STOP: begin
        if (wake_event) begin
          mode_next = clock_mode_pkg::MODE_RUN;
        end
      end
      default: mode_next = clock_mode_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_reg <= clock_mode_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign wr_clks = reg_write && (reg_addr == clock_mode_pkg::CLOCK_SELECT_OFFSET);

  // clock select bits; wake from full stop forces the pll setup back
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      clks_reg <= clock_mode_pkg::CLOCK_SELECT_RESET;
    end else if (mode_reg == clock_mode_pkg::MODE_FULL_STOP && wake_event) begin
      clks_reg.bus_clock_from_pll_select <= 1'b1;
      clks_reg.watchdog_clk_osc_select <= 1'b0;
      clks_reg.periodic_timer_clk_select <= 1'b0;
    end else if (wr_clks && mode_reg == clock_mode_pkg::MODE_RUN) begin
      clks_reg <= reg_wdata;
    end
  end

  // remaining software controls; no writes land while the core is stopped
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wdog_ctrl_reg <= clock_mode_pkg::WATCHDOG_CTRL_RESET;
      osc_enable_reg <= 1'b0;
      vco_reg <= clock_mode_pkg::VCO_TARGET_RESET;
      ref_div_reg <= clock_mode_pkg::REF_DIV_RESET;
      post_div_reg <= clock_mode_pkg::POST_DIV_RESET;
    end else if (reg_write && mode_reg == clock_mode_pkg::MODE_RUN) begin
      case (reg_addr)
        clock_mode_pkg::WATCHDOG_CTRL_OFFSET: begin
          wdog_ctrl_reg <= {reg_wdata[7:6], 3'h0, reg_wdata[2:0]};
        end
        clock_mode_pkg::OSC_CTRL_OFFSET: osc_enable_reg <= reg_wdata[clock_mode_pkg::OSC_CTRL_ENABLE_BIT];
        clock_mode_pkg::VCO_TARGET_OFFSET: vco_reg <= reg_wdata;
        clock_mode_pkg::REF_DIV_OFFSET: ref_div_reg <= reg_wdata[3:0];
        clock_mode_pkg::POST_DIV_OFFSET: post_div_reg <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // reset cause flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reset_flags_reg <= 5'h00;
    end else begin
      reset_flags_reg <= (reset_flags_reg
        & ~((reg_write && reg_addr == clock_mode_pkg::RESET_FLAGS_OFFSET) ?
            reg_wdata[4:0] : 5'h00))
        | {reset_sources.power_on, reset_sources.low_voltage & low_voltage_monitor_enable,
           reset_sources.watchdog_timeout, reset_sources.osc_clock_loss,
           reset_sources.pll_clock_loss};
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      clock_mode_pkg::RESET_FLAGS_OFFSET: rd_mux = {3'h0, reset_flags_reg};
      clock_mode_pkg::VCO_TARGET_OFFSET: rd_mux = vco_reg;
      clock_mode_pkg::REF_DIV_OFFSET: rd_mux = {4'h0, ref_div_reg};
      clock_mode_pkg::POST_DIV_OFFSET: rd_mux = {3'h0, post_div_reg};
      clock_mode_pkg::STATUS_OFFSET: begin
        rd_mux[clock_mode_pkg::STATUS_LOCK_BIT] = pll_lock_flag;
        rd_mux[clock_mode_pkg::STATUS_OSC_UP_BIT] = osc_up_flag;
      end
      clock_mode_pkg::CLOCK_SELECT_OFFSET: rd_mux = clks_reg;
      clock_mode_pkg::WATCHDOG_CTRL_OFFSET: rd_mux = wdog_ctrl_reg;
      clock_mode_pkg::OSC_CTRL_OFFSET: rd_mux[clock_mode_pkg::OSC_CTRL_ENABLE_BIT] = osc_enable_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_reg;

  // break-before-make: old gate drops, a dead gap, then the new gate rises
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pll_gate_reg <= 1'b1;
      osc_gate_reg <= 1'b0;
      gap_reg <= 2'h0;
    end else if (clks_reg.bus_clock_from_pll_select ? osc_gate_reg : pll_gate_reg) begin
      pll_gate_reg <= 1'b0;
      osc_gate_reg <= 1'b0;
      gap_reg <= 2'(clock_mode_pkg::SWITCH_GAP_CYCLES);
    end else if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end else begin
      pll_gate_reg <= clks_reg.bus_clock_from_pll_select;
      osc_gate_reg <= ~clks_reg.bus_clock_from_pll_select && osc_up_flag;
    end
  end

  // timer clock selection across run, debug freeze and both stop modes
  always_comb begin
    wdog_next.count_enable = 1'b1;
    wdog_next.source = clks_reg.watchdog_clk_aclk_select ? clock_mode_pkg::SRC_ACLK :
      (clks_reg.watchdog_clk_osc_select ? clock_mode_pkg::SRC_OSC : clock_mode_pkg::SRC_IRC);
    rti_next.count_enable = 1'b1;
    rti_next.source = clks_reg.periodic_timer_clk_select ? clock_mode_pkg::SRC_OSC :
      clock_mode_pkg::SRC_IRC;
    case (mode_reg)
      clock_mode_pkg::MODE_RUN: begin
        if (background_debug_active && wdog_ctrl_reg.freeze_hold_timers) begin
          wdog_next.count_enable = 1'b0;
          rti_next.count_enable = 1'b0;
        end
      end
      clock_mode_pkg::MODE_FULL_STOP: begin
        rti_next.count_enable = 1'b0;
        wdog_next.count_enable = clks_reg.watchdog_clk_aclk_select
          && !clks_reg.cop_stop_aclk_disable;
      end
      clock_mode_pkg::MODE_PSEUDO_STOP: begin
        rti_next.source = clock_mode_pkg::SRC_OSC;
        rti_next.count_enable = clks_reg.periodic_timer_pseudo_stop_enable;
        if (clks_reg.watchdog_clk_aclk_select) begin
          wdog_next.count_enable = !clks_reg.cop_stop_aclk_disable;
        end else begin
          wdog_next.source = clock_mode_pkg::SRC_OSC;
          wdog_next.count_enable = clks_reg.watchdog_pseudo_stop_enable;
        end
      end
      default: begin
        wdog_next.count_enable = 1'b0;
        rti_next.count_enable = 1'b0;
      end
    endcase
  end

  // registered power and clock enables from the mode; pll reference from the oscillator
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      core_clock_enable <= 1'b1;
      pll_enable <= 1'b1;
      internal_ref_enable <= 1'b1;
      pll_ref_from_osc <= 1'b0;
      osc_run <= 1'b0;
      low_voltage_monitor_enable <= 1'b1;
      watchdog_clock <= '0;
      periodic_timer_clock <= '0;
      watchdog_force_max <= 1'b0;
    end else begin
      core_clock_enable <= (mode_reg == clock_mode_pkg::MODE_RUN);
      pll_enable <= (mode_reg == clock_mode_pkg::MODE_RUN);
      internal_ref_enable <= (mode_reg == clock_mode_pkg::MODE_RUN);
      pll_ref_from_osc <= osc_enable_reg && osc_up_flag;
      osc_run <= osc_enable_reg && (mode_reg != clock_mode_pkg::MODE_FULL_STOP);
      low_voltage_monitor_enable <= (mode_reg == clock_mode_pkg::MODE_RUN);
      watchdog_clock <= wdog_next;
      periodic_timer_clock <= rti_next;
      // longest time-out only while debug runs the watchdog unfrozen
      watchdog_force_max <= background_debug_active && !wdog_ctrl_reg.freeze_hold_timers
        && (wdog_ctrl_reg.watchdog_rate != 3'h0);
    end
  end

  // the periodic interrupt keeps its own clock in every mode
  assign autonomous_periodic_enable = 1'b1;

  // reset sources; low voltage only counts while its monitor is on
  assign reset_trigger = reset_sources.power_on
    || (reset_sources.low_voltage && low_voltage_monitor_enable)
    || reset_sources.watchdog_timeout || reset_sources.osc_clock_loss
    || reset_sources.pll_clock_loss
    || (pin_low && pulse_reg == 8'h00 && pin_mask_reg == 3'h0);

  // stretch the pulse on the pin; mask our own echo while the pin recovers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pulse_reg <= 8'h00;
      pin_mask_reg <= 3'h0;
    end else begin
      if (reset_trigger) begin
        pulse_reg <= 8'(RESET_PULSE);
      end else if (pulse_reg != 8'h00) begin
        pulse_reg <= pulse_reg - 8'h01;
      end
      if (pulse_reg != 8'h00) begin
        pin_mask_reg <= 3'(clock_mode_pkg::PIN_MASK_CYCLES);
      end else if (pin_mask_reg != 3'h0) begin
        pin_mask_reg <= pin_mask_reg - 3'h1;
      end
    end
  end

  assign system_reset = (pulse_reg != 8'h00);
  assign reset_pin_oe = (pulse_reg != 8'h00);
  assign reset_pin_out = 1'b0; // open drain only ever pulls low
  assign stop_mode = mode_reg;
  assign bus_clock_pll_gate = pll_gate_reg;
  assign bus_clock_osc_gate = osc_gate_reg;
  assign vco_target_mhz = vco_reg;
  assign ref_divider = ref_div_reg;
  assign post_divider = post_div_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_reset_pll;
    $rose(reset_n) |-> clks_reg.bus_clock_from_pll_select && pll_gate_reg && !osc_gate_reg;
  endproperty
  a_reset_pll: assert property (p_reset_pll) else $error("not on pll after reset");

  property p_reset_div;
    $rose(reset_n) |-> post_divider == 5'h03 && vco_target_mhz == 8'h32;
  endproperty
  a_reset_div: assert property (p_reset_div) else $error("bad pll reset setup");

  property p_stop_off;
    mode_reg != clock_mode_pkg::MODE_RUN ##1 mode_reg != clock_mode_pkg::MODE_RUN
      |-> !pll_enable && !internal_ref_enable && !core_clock_enable
        && !low_voltage_monitor_enable;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("clocks alive in stop");

  property p_full_choice;
    mode_reg == clock_mode_pkg::MODE_RUN && stop_request
      && !(clks_reg.pseudo_stop_select && osc_enable_reg)
      |=> mode_reg == clock_mode_pkg::MODE_FULL_STOP ##1 !osc_run;
  endproperty
  a_full_choice: assert property (p_full_choice) else $error("wrong stop kind");

  property p_full_halt;
    mode_reg == clock_mode_pkg::MODE_FULL_STOP && !clks_reg.watchdog_clk_aclk_select
      |=> !watchdog_clock.count_enable && !periodic_timer_clock.count_enable;
  endproperty
  a_full_halt: assert property (p_full_halt) else $error("timers run in full stop");

  property p_wake_full;
    mode_reg == clock_mode_pkg::MODE_FULL_STOP && wake_event |=> clks_reg[7]
      && !clks_reg.watchdog_clk_osc_select && !clks_reg.periodic_timer_clk_select;
  endproperty
  a_wake_full: assert property (p_wake_full) else $error("wake did not restore pll");

  property p_pseudo_keep;
    mode_reg == clock_mode_pkg::MODE_PSEUDO_STOP && wake_event |=> $stable(clks_reg);
  endproperty
  a_pseudo_keep: assert property (p_pseudo_keep) else $error("pseudo stop moved bits");

  property p_freeze;
    mode_reg == clock_mode_pkg::MODE_RUN && background_debug_active
      && wdog_ctrl_reg.freeze_hold_timers
      |=> !watchdog_clock.count_enable && !periodic_timer_clock.count_enable;
  endproperty
  a_freeze: assert property (p_freeze) else $error("timers not frozen");

  property p_wdog_reset;
    reset_sources.watchdog_timeout |=> (system_reset && reset_pin_oe) [*8];
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("no reset pulse");

  property p_gap;
    $fell(pll_gate_reg) |-> !osc_gate_reg ##1 !osc_gate_reg && !pll_gate_reg;
  endproperty
  a_gap: assert property (p_gap) else $error("no dead gap on switch");

  c_full: cover property (mode_reg == clock_mode_pkg::MODE_FULL_STOP ##1 wake_event);
  c_pseudo: cover property (mode_reg == clock_mode_pkg::MODE_PSEUDO_STOP);
  c_to_osc: cover property ($rose(osc_gate_reg));
  c_pin: cover property ($rose(reset_pin_oe));

endmodule

// ==== bench/analog_partner.sv ====
`timescale 1ns/100ps
// oscillator and pll stand-in: each flag follows its enable after a start-up delay
module analog_partner #(
  parameter int STARTUP = 20
) (
  input wire logic clock,
  input wire logic osc_run,
  input wire logic pll_enable,
  output logic osc_up_raw,
  output logic pll_lock_raw
);
  int osc_count = 0;
  int pll_count = 0;

  initial begin
    osc_up_raw = 1'b0;
    pll_lock_raw = 1'b0;
  end

  // flags drop at once when the source stops, so no stale flag survives a stop
  always @(posedge clock) begin
    osc_count <= osc_run ? osc_count + 1 : 0;
    pll_count <= pll_enable ? pll_count + 1 : 0;
    osc_up_raw <= osc_run && osc_count >= STARTUP;
    pll_lock_raw <= pll_enable && pll_count >= STARTUP / 2;
  end
endmodule

// ==== bench/clock_mode_stop_control_tb.sv ====
`timescale 1ns/100ps
module clock_mode_stop_control_tb;
  localparam int PULSE = 8;
  localparam logic [7:0] CS = clock_mode_pkg::CLOCK_SELECT_OFFSET;
  logic clock, reset_n, reg_write, reg_read, stop_request, wake_event, debug, ext_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_value, vco_target_mhz;
  logic [4:0] post_divider;
  clock_mode_pkg::reset_sources_s reset_sources;
  clock_mode_pkg::stop_mode_e stop_mode;
  clock_mode_pkg::timer_clock_s watchdog_clock, periodic_timer_clock;
  logic osc_up_raw, pll_lock_raw, reset_pin_out, reset_pin_oe, system_reset, pll_ref_from_osc;
  logic bus_clock_pll_gate, bus_clock_osc_gate, core_clock_enable, pll_enable, osc_run;
  logic internal_ref_enable, low_voltage_monitor_enable, autonomous_periodic_enable;
  logic watchdog_force_max;
  wire reset_pin;
  int num_errors = 0;
  int samples_checked = 0;

  // pin has a pull-up; the device or the bench may pull it low
  assign reset_pin = ~ext_low & (reset_pin_oe ? reset_pin_out : 1'b1);

  clock_mode_stop_control #(.RESET_PULSE(PULSE)) dut (.clock, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .stop_request, .wake_event,
    .background_debug_active(debug), .osc_up_raw, .pll_lock_raw, .reset_sources,
    .reset_pin_in(reset_pin), .reset_pin_out, .reset_pin_oe, .system_reset, .stop_mode,
    .bus_clock_pll_gate, .bus_clock_osc_gate, .core_clock_enable, .pll_enable,
    .internal_ref_enable, .pll_ref_from_osc, .osc_run, .low_voltage_monitor_enable,
    .autonomous_periodic_enable, .vco_target_mhz, .ref_divider(), .post_divider,
    .watchdog_clock, .periodic_timer_clock, .watchdog_force_max);

  analog_partner partner (.clock, .osc_run, .pll_enable, .osc_up_raw, .pll_lock_raw);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // settle past the edge so registered outputs are stable
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rd_value = reg_rdata;
  endtask

  task automatic wait_osc_up;
    int n = 0;
    rd(clock_mode_pkg::STATUS_OFFSET);
    while (rd_value[0] !== 1'b1 && n < 200) begin
      rd(clock_mode_pkg::STATUS_OFFSET);
      n++;
    end
    if (rd_value[0] !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic pulse_stop(input logic wake);
    @(posedge clock);
    if (wake) wake_event <= 1'b1;
    else stop_request <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    stop_request <= 1'b0;
    tick(2);
  endtask

  task automatic t_reset_values;
    rd(CS);
    check(rd_value, clock_mode_pkg::CLOCK_SELECT_RESET);
    check(8'(post_divider), 8'h03);
    check(vco_target_mhz, 8'h32);
    check(8'({pll_ref_from_osc, bus_clock_pll_gate, bus_clock_osc_gate}), 8'h02);
    rd(8'h0D);
    check(rd_value, 8'h00);
    $display("reset values done");
  endtask

  task automatic t_bypass;
    wr(clock_mode_pkg::OSC_CTRL_OFFSET, 8'h80);
    wait_osc_up();
    tick(20);
    rd(clock_mode_pkg::STATUS_OFFSET);
    check(rd_value & 8'h09, 8'h09);
    wr(CS, 8'h03);
    tick(6);
    check(8'({bus_clock_pll_gate, bus_clock_osc_gate, pll_enable}), 8'h03);
    $display("bypass done");
  endtask

  // one stop entry and exit; state is {mode, watchdog clock, periodic clock}
  task automatic run_stop(input logic [7:0] sel, input logic [7:0] mask,
                          input logic [7:0] exp, input logic [7:0] after);
    wait_osc_up();
    wr(CS, sel);
    pulse_stop(1'b0);
    check(8'({stop_mode, watchdog_clock, periodic_timer_clock}) & mask, exp);
    check(8'({core_clock_enable, pll_enable, internal_ref_enable,
      low_voltage_monitor_enable, autonomous_periodic_enable}), 8'h01);
    check(8'(osc_run), 8'(sel[6]));
    pulse_stop(1'b1);
    rd(CS);
    check(rd_value, after);
    check(8'({core_clock_enable, pll_enable}), 8'h03);
  endtask

  task automatic t_stops;
    run_stop(8'h03, 8'hE4, 8'h40, 8'h80);
    run_stop(8'h13, 8'hFC, 8'h70, 8'h90);
    run_stop(8'hCC, 8'hFF, 8'hAD, 8'hCC);
    run_stop(8'hD8, 8'hFF, 8'hB5, 8'hD8);
    run_stop(8'hF8, 8'hFF, 8'h95, 8'hF8);
    $display("stop modes done");
  endtask

  task automatic t_debug;
    wr(clock_mode_pkg::WATCHDOG_CTRL_OFFSET, 8'h40);
    tick(2);
    check(8'({watchdog_clock.count_enable, periodic_timer_clock.count_enable}), 8'h03);
    @(posedge clock);
    debug <= 1'b1;
    tick(3);
    check(8'({watchdog_clock.count_enable, periodic_timer_clock.count_enable}), 8'h00);
    wr(clock_mode_pkg::WATCHDOG_CTRL_OFFSET, 8'h03);
    tick(3);
    check(8'({watchdog_clock.count_enable, watchdog_force_max}), 8'h03);
    @(posedge clock);
    debug <= 1'b0;
    tick(3);
    check(8'(watchdog_force_max), 8'h00);
    $display("debug done");
  endtask

  // count pulse cycles on the pin and on the system reset in a fixed window
  task automatic t_reset_sources;
    int n_sys = 0;
    int n_pin = 0;
    @(posedge clock);
    reset_sources <= 5'h04;
    @(posedge clock);
    reset_sources <= '0;
    #1;
    // the pulse starts at this edge, so sample before waiting
    for (int i = 0; i < 40; i++) begin
      if (system_reset === 1'b1) n_sys++;
      if (reset_pin === 1'b0) n_pin++;
      tick(1);
    end
    check(8'(n_sys), 8'(PULSE));
    check(8'(n_pin), 8'(PULSE));
    // the chip reset tree answers the pulse through reset_n
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(CS);
    check(rd_value, clock_mode_pkg::CLOCK_SELECT_RESET);
    n_sys = 0;
    @(posedge clock);
    ext_low <= 1'b1;
    repeat (8) @(posedge clock);
    ext_low <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (system_reset === 1'b1) n_sys++;
    end
    check(8'(n_sys != 0), 8'h01);
    $display("reset sources done");
  endtask

  initial begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    stop_request = 1'b0;
    wake_event = 1'b0;
    debug = 1'b0;
    ext_low = 1'b0;
    reset_sources = '0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    t_reset_values();
    t_bypass();
    t_stops();
    t_debug();
    t_reset_sources();
    final_report();
  end
endmodule
